/* File: core/cbf_pkg.sv */
// package: constants and types for the cache block fetch control
package cbf_pkg;
   // ========================================
   // instruction address split
   localparam int TAG_MSB      = 31;
   localparam int TAG_LSB      = 12;
   localparam int LINE_MSB     = 11;
   localparam int LINE_LSB     = 4;
   localparam int WORD_MSB     = 3;
   localparam int WORD_LSB     = 2;
   localparam int TAG_W        = TAG_MSB - TAG_LSB + 1;
   localparam int LINE_W       = LINE_MSB - LINE_LSB + 1;
   localparam int WORD_W       = WORD_MSB - WORD_LSB + 1;
   localparam int WORDS_PER_LN = 1 << WORD_W;
   localparam int ICACHE_BYTES = 4096;
   // ========================================
   // configuration bits
   localparam int CFG_DCD_BIT  = 22;
   localparam int CFG_DBS_LSB  = 18;
   localparam int CFG_DBS_MSB  = 19;
   localparam int CFG_BFD_BIT  = 0;
   localparam logic CFG_DCD_RESET = 1'b0;
   // ========================================
   // uncached kernel segment: top three address bits 3'b101
   localparam logic [2:0] UNCACHED_SEG = 3'h5;
   // ========================================
   typedef struct packed {
      logic [TAG_W-1:0]  tag;
      logic [LINE_W-1:0] line;
      logic [WORD_W-1:0] word;
   } cbf_iaddr_t;
   typedef struct packed {
      logic [TAG_W-1:0]        tag;
      logic [WORDS_PER_LN-1:0] valid;
   } cbf_itag_t;
   typedef enum logic [1:0] {
      CBF_IDLE  = 2'b00,
      CBF_REQ   = 2'b01,
      CBF_BLOCK = 2'b11,
      CBF_WORD  = 2'b10
   } cbf_state_t;
endpackage

/* File: core/cbf_itag_store.sv */
// instruction tag store indexed by line number
`timescale 1ns/1ps
`default_nettype none
module cbf_itag_store
   import cbf_pkg::*;
(
   // clock and reset
   input  wire  logic              mclk,
   input  wire  logic              reset_n,
   // lookup
   input  wire  cbf_iaddr_t        lookAddr,
   output logic                    hit,
   // fill
   input  wire  logic              fillEn,
   input  wire  cbf_iaddr_t        fillAddr
);
   // ========================================
   // storage
   cbf_itag_t tagMem [0:(1<<LINE_W)-1];
   logic [(1<<LINE_W)-1:0] lineLive;
   cbf_itag_t lookEntry;

   assign lookEntry = tagMem[lookAddr.line];
   // hit needs a tag match and the word's valid bit
   assign hit = lineLive[lookAddr.line] && (lookEntry.tag == lookAddr.tag)
                && lookEntry.valid[lookAddr.word];

   // ========================================
   // live bits reset so the array itself needs none
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lineLive <= '0;
      end else if (fillEn) begin
         lineLive[fillAddr.line] <= 1'b1;
      end
   end

   // tag plus per-word valid stored together
   always_ff @(posedge mclk) begin
      if (fillEn) begin
         if (lineLive[fillAddr.line] && tagMem[fillAddr.line].tag == fillAddr.tag) begin
            tagMem[fillAddr.line].valid[fillAddr.word] <= 1'b1;
         end else begin
            tagMem[fillAddr.line].tag   <= fillAddr.tag;
            tagMem[fillAddr.line].valid <= WORDS_PER_LN'(1) << fillAddr.word;
         end
      end
   end
endmodule
`default_nettype wire

/* File: core/cbf_control.sv */
// cache block fetch control: miss handling, fill decision, data cache disable
// Operation
// - on a cacheable miss, raise the block fetch request
// - internal DRAM controller acknowledges when block fetch not disabled; block cached
// - external acknowledge means fetched words are cached regardless of cacheable_n
// - no acknowledge: fetch one word, cache it only if cacheable_n asserted
// - uncached kernel segment: never request a block, never cache
// - instruction address: tag 31..12, line 11..4, word 3..2
// - tag entry holds the address tag (bits 31..12) with per-word valid bits
// - reset clears data cache disable bit 22
// - data cache disabled: loads and stores go straight to memory
// - data cache disabled: block size bits 18 and 19 ignored
// - without data cache, cacheable_n only steers instruction fills
`timescale 1ns/1ps
`default_nettype none
module cbf_control
   import cbf_pkg::*;
#(
   parameter int DRAM_BASE_HI = 4'h0,
   parameter int DRAM_TOP_HI  = 4'h1
)
(
   // clock and reset
   input  wire  logic              mclk,
   input  wire  logic              reset_n,
   // processor access request
   input  wire  logic              missReq,
   input  wire  logic              missIsData,
   input  wire  logic [31:0]       missAddr,
   input  wire  logic              wordDone,
   input  wire  logic              lastWord,
   // configuration write
   input  wire  logic              cfgWrite,
   input  wire  logic [31:0]       cfgData,
   // memory side pins
   input  wire  logic              block_fetch_ack_n,
   input  wire  logic              cacheable_n,
   input  wire  logic              dramBlockAck,
   output logic                    block_fetch_request,
   output logic                    addr_strobe_out_n,
   // cache fill controls
   output logic                    icacheFill,
   output logic                    dcacheFill,
   output logic                    dcacheBypass,
   output logic                    icacheHit,
   output logic                    blockMode,
   output logic [1:0]              dcacheBlockSize,
   output logic                    dcache_disable
);
   // ========================================
   // pin synchronisers
   logic [1:0] ackSync;
   logic [1:0] cachSync;
   logic       ackN;
   logic       cachN;

   // both pins idle high, so reset loads ones and no false ack follows
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ackSync <= 2'h3;
      end else begin
         ackSync <= {ackSync[0], block_fetch_ack_n};
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cachSync <= 2'h3;
      end else begin
         cachSync <= {cachSync[0], cacheable_n};
      end
   end
   assign ackN  = ackSync[1];
   assign cachN = cachSync[1];

   // ========================================
   // configuration register
   logic blockFetchDisable;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dcache_disable <= CFG_DCD_RESET;
      end else if (cfgWrite) begin
         dcache_disable <= cfgData[CFG_DCD_BIT];
      end
   end

   // flag position is our own choice
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blockFetchDisable <= 1'b0;
      end else if (cfgWrite) begin
         blockFetchDisable <= cfgData[CFG_BFD_BIT];
      end
   end

   // loaded by the same write, so it never lags the disable bit
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dcacheBlockSize <= 2'h0;
      end else if (cfgWrite) begin
         dcacheBlockSize <= cfgData[CFG_DCD_BIT] ? 2'h0
                            : cfgData[CFG_DBS_MSB:CFG_DBS_LSB];
      end
   end

   // ========================================
   // address classification
   function automatic logic isUncached(input logic [31:0] a);
      return a[31:29] == UNCACHED_SEG;
   endfunction

   function automatic logic inDram(input logic [31:0] a);
      return (int'(a[31:28]) >= DRAM_BASE_HI) && (int'(a[31:28]) <= DRAM_TOP_HI);
   endfunction

   cbf_iaddr_t iaddr;
   assign iaddr = cbf_iaddr_t'(missAddr[TAG_MSB:WORD_LSB]);

   logic dataBypass;
   logic cacheableMiss;
   // data with the cache off goes straight to memory, never requests a block
   assign dataBypass    = missIsData && dcache_disable;
   assign cacheableMiss = !isUncached(missAddr) && !dataBypass;

   // ========================================
   // miss sequencer
   cbf_state_t state;
   cbf_state_t next_state;
   logic       curData;
   logic       curBypass;
   logic       curUncached;
   cbf_iaddr_t curAddr;
   logic       blockAcked;

   logic       dramAcked;
   logic       extAcked;
   logic       reqAccept;
   // dram ack only counts when block fetch is enabled for that space
   assign dramAcked  = inDram({curAddr, 2'b00}) && !blockFetchDisable
                       && dramBlockAck;
   assign extAcked   = !ackN;
   assign blockAcked = dramAcked || extAcked;
   // a miss is taken only in idle
   assign reqAccept  = (state == CBF_IDLE) && missReq;

   always_comb begin
      next_state = state;
      case (state)
         CBF_IDLE: begin
            if (missReq) begin
               next_state = CBF_REQ;
            end
         end
         CBF_REQ: begin
            if (curUncached || curBypass) begin
               next_state = CBF_WORD;
            end else if (blockAcked) begin
               next_state = CBF_BLOCK;
            end else begin
               next_state = CBF_WORD;
            end
         end
         CBF_BLOCK: begin
            if (wordDone && lastWord) begin
               next_state = CBF_IDLE;
            end
         end
         CBF_WORD: begin
            if (wordDone) begin
               next_state = CBF_IDLE;
            end
         end
         default: begin
            next_state = CBF_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= CBF_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         curData     <= 1'b0;
         curBypass   <= 1'b0;
         curUncached <= 1'b0;
      end else if (reqAccept) begin
         curData     <= missIsData;
         curBypass   <= dataBypass;
         curUncached <= isUncached(missAddr);
      end
   end

   // word offset steps once per block word
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         curAddr <= '0;
      end else if (reqAccept) begin
         curAddr <= iaddr;
      end else if (wordDone && state == CBF_BLOCK) begin
         curAddr.word <= curAddr.word + 2'h1;
      end
   end

   // ========================================
   // pin outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         block_fetch_request <= 1'b0;
      end else begin
         block_fetch_request <= reqAccept && cacheableMiss;
      end
   end

   // strobe spans the transfer; external ack is held until it rises
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         addr_strobe_out_n <= 1'b1;
      end else begin
         addr_strobe_out_n <= (next_state == CBF_IDLE);
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         blockMode <= 1'b0;
      end else begin
         blockMode <= (next_state == CBF_BLOCK);
      end
   end

   // ========================================
   // fill decision
   logic fillNow;
   logic fillIsData;
   logic fillIsInstr;
   always_comb begin
      fillNow = 1'b0;
      if (wordDone && !curUncached && !curBypass) begin
         if (state == CBF_BLOCK) begin
            fillNow = 1'b1;
         end else if (state == CBF_WORD) begin
            fillNow = !cachN;
         end
      end
   end
   // a data fill is never made with the cache disabled
   assign fillIsData = fillNow && curData && !dcache_disable;
   assign fillIsInstr = fillNow && !curData;

   // fill pulses follow the word that made them by one cycle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         icacheFill <= 1'b0;
      end else begin
         icacheFill <= fillIsInstr;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dcacheFill <= 1'b0;
      end else begin
         dcacheFill <= fillIsData;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dcacheBypass <= 1'b0;
      end else begin
         dcacheBypass <= dcache_disable;
      end
   end

   // ========================================
   // instruction tag store
   logic hitNow;
   cbf_itag_store u_itag (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .lookAddr (iaddr),
      .hit      (hitNow),
      .fillEn   (fillIsInstr),
      .fillAddr (curAddr)
   );

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         icacheHit <= 1'b0;
      end else begin
         icacheHit <= hitNow && !missIsData;
      end
   end
endmodule
`default_nettype wire

/* File: test/cbf_control_monitor.sv */
// checker: port assertions for the block fetch control
`timescale 1ns/1ps
`default_nettype none
module cbf_control_monitor
   import cbf_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset_n,
   // watched ports
   input wire logic        missReq,
   input wire logic [31:0] missAddr,
   input wire logic        wordDone,
   input wire logic        lastWord,
   input wire logic        block_fetch_request,
   input wire logic        addr_strobe_out_n,
   input wire logic        icacheFill,
   input wire logic        dcacheFill,
   input wire logic        dcacheBypass,
   input wire logic [1:0]  dcacheBlockSize,
   input wire logic        dcache_disable
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ========================================
   // assertions
   req_cause_a: assert property (
      block_fetch_request |-> $past(missReq) && $past(missAddr[31:29]) != UNCACHED_SEG)
      else $error("request without cacheable miss");
   req_pulse_a: assert property (
      block_fetch_request |=> !block_fetch_request) else $error("request longer than one cycle");
   req_strobe_a: assert property (
      block_fetch_request |-> !addr_strobe_out_n) else $error("request without strobe");
   strobe_end_a: assert property (
      !addr_strobe_out_n && wordDone && lastWord |=> addr_strobe_out_n)
      else $error("strobe held after last word");
   ifill_word_a: assert property (
      icacheFill |-> $past(wordDone)) else $error("instruction fill without word");
   dfill_word_a: assert property (
      dcacheFill |-> $past(wordDone) && !dcacheBypass) else $error("bad data fill");
   size_ignored_a: assert property (
      dcache_disable |-> dcacheBlockSize == 2'h0) else $error("block size seen while disabled");
   bypass_track_a: assert property (
      dcacheBypass == $past(dcache_disable)) else $error("bypass not following disable");
   reset_clear_a: assert property (
      !$past(reset_n) |-> !dcache_disable) else $error("disable set out of reset");
   cover property (block_fetch_request);
   cover property (dcacheFill);
   cover property (dcache_disable);
endmodule
bind cbf_control cbf_control_monitor mon_u (.mclk, .reset_n, .missReq, .missAddr, .wordDone,
   .lastWord, .block_fetch_request, .addr_strobe_out_n, .icacheFill, .dcacheFill,
   .dcacheBypass, .dcacheBlockSize, .dcache_disable);
`default_nettype wire

/* File: test/cbf_mem_model.sv */
// memory system model: block acknowledge and word return
`timescale 1ns/1ps
`default_nettype none
module cbf_mem_model (
   // clock and strobe
   input  wire logic       mclk,
   input  wire logic       addr_strobe_out_n,
   // scenario controls
   input  wire logic       ackExt,
   input  wire logic       ackDram,
   input  wire logic       cacheN,
   input  wire logic [3:0] gap,
   // answers
   output logic            block_fetch_ack_n,
   output logic            cacheable_n,
   output logic            dramBlockAck,
   output var logic        wordDone,
   output var logic        lastWord
);
   int i;
   int n;
   // pin pulled up when idle; bench keeps it low until strobe rises
   assign block_fetch_ack_n = !ackExt;
   assign cacheable_n = cacheN;
   // internal controller answers only while a transfer is open
   assign dramBlockAck = ackDram && !addr_strobe_out_n;
   initial begin
      wordDone = 1'b0;
      lastWord = 1'b0;
      forever begin
         @(negedge mclk);
         if (!addr_strobe_out_n) begin
            n = (ackExt || ackDram) ? 4 : 1;
            @(posedge mclk);
            repeat (gap) @(posedge mclk);
            for (i = 1; i <= n; i++) begin
               wordDone <= 1'b1;
               lastWord <= (i == n);
               @(posedge mclk);
               if (gap != 4'h0) begin
                  wordDone <= 1'b0;
                  lastWord <= 1'b0;
                  repeat (gap) @(posedge mclk);
               end
            end
            wordDone <= 1'b0;
            lastWord <= 1'b0;
            @(negedge mclk);
            while (!addr_strobe_out_n) @(negedge mclk);
         end
      end
   end
endmodule
`default_nettype wire

/* File: test/cbf_control_bench.sv */
// testbench: block fetch control scenarios
`timescale 1ns/1ps
`default_nettype none
module cbf_control_bench;
   import cbf_pkg::*;
   logic mclk, reset_n, missReq, missIsData, cfgWrite, ackExt, ackDram, cacheN;
   logic [31:0] missAddr, cfgData;
   logic [3:0] gap;
   logic wordDone, lastWord, block_fetch_ack_n, cacheable_n, dramBlockAck;
   logic block_fetch_request, addr_strobe_out_n, icacheFill, dcacheFill, dcacheBypass;
   logic icacheHit, dcache_disable, blockMode, sawBlock;
   logic [1:0] dcacheBlockSize;
   logic [7:0] nReq, nIf, nDf;
   int n_fail, n_compared, cyc;
   cbf_control dut_u (.mclk, .reset_n, .missReq, .missIsData, .missAddr, .wordDone,
      .lastWord, .cfgWrite, .cfgData, .block_fetch_ack_n, .cacheable_n, .dramBlockAck,
      .block_fetch_request, .addr_strobe_out_n, .icacheFill, .dcacheFill, .dcacheBypass,
      .icacheHit, .blockMode, .dcacheBlockSize, .dcache_disable);
   cbf_mem_model mem_u (.mclk, .addr_strobe_out_n, .ackExt, .ackDram, .cacheN, .gap,
      .block_fetch_ack_n, .cacheable_n, .dramBlockAck, .wordDone, .lastWord);
   // ========================================
   // checking and closing
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      if (block_fetch_request) nReq <= nReq + 8'h01;
      if (icacheFill) nIf <= nIf + 8'h01;
      if (dcacheFill) nDf <= nDf + 8'h01;
      if (blockMode) sawBlock <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         wrap_up();
      end
   end
   // ========================================
   // scenarios
   task automatic miss(input logic [31:0] a, input logic d, x, r, c,
                       input logic [7:0] q, f, g);
      @(posedge mclk);
      ackExt <= x;
      ackDram <= r;
      cacheN <= c;
      missAddr <= a;
      missIsData <= d;
      // pins pass a two-flop synchroniser before the decision
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      nReq = 8'h00;
      nIf = 8'h00;
      nDf = 8'h00;
      sawBlock = 1'b0;
      @(posedge mclk);
      missReq <= 1'b1;
      @(posedge mclk);
      missReq <= 1'b0;
      repeat (24) @(posedge mclk);
      ackExt <= 1'b0;
      ackDram <= 1'b0;
      chk("strobe", 8'h01, addr_strobe_out_n);
      chk("request", q, nReq);
      chk("ifill", f, nIf);
      chk("dfill", g, nDf);
      chk("block mode", {7'h00, (x | r) & q[0]}, {7'h00, sawBlock});
   endtask
   task automatic hit(input logic [31:0] a, input logic e);
      @(posedge mclk);
      missAddr <= a;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("hit", e, icacheHit);
   endtask
   task automatic cfg(input logic [31:0] v, input logic dcd, input logic [1:0] bs);
      @(posedge mclk);
      cfgWrite <= 1'b1;
      cfgData <= v;
      @(posedge mclk);
      cfgWrite <= 1'b0;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("disable", dcd, dcache_disable);
      chk("bypass", dcd, dcacheBypass);
      chk("size", bs, dcacheBlockSize);
   endtask
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      {reset_n, missReq, missIsData, cfgWrite, ackExt, ackDram, cacheN} = 7'h01;
      {missAddr, cfgData, gap, nReq, nIf, nDf} = '0;
      n_fail = 0;
      n_compared = 0;
      cyc = 0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(negedge mclk);
      chk("reset disable", 8'h00, dcache_disable);
      miss(32'h4000_1000, 1'b0, 1'b1, 1'b0, 1'b1, 8'h01, 8'h04, 8'h00);
      hit(32'h4000_100C, 1'b1);
      hit(32'h4000_2000, 1'b0);
      hit(32'h4000_1010, 1'b0);
      @(posedge mclk);
      gap <= 4'h2;
      miss(32'h0000_2040, 1'b1, 1'b0, 1'b1, 1'b1, 8'h01, 8'h00, 8'h04);
      miss(32'h4000_3000, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01, 8'h00, 8'h00);
      miss(32'h4000_3100, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h01);
      miss(32'hA000_0000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      cfg(32'h004C_0000, 1'b1, 2'h0);
      miss(32'h4000_4000, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      miss(32'h4000_5000, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01, 8'h01, 8'h00);
      cfg(32'h0008_0000, 1'b0, 2'h2);
      wrap_up();
   end
endmodule
`default_nettype wire
